/* File: dv/iexdp_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module iexdp_bench;
    import iexdp_pkg::*;
    logic        mclk;
    logic        rst_b;
    logic        req_valid;
    iexdp_req_t  req;
    logic [31:0] mem_word;
    logic [63:0] cop_val;
    logic        busy;
    iexdp_wb_t   wb;
    logic [63:0] mem_addr;
    logic        addr_err;
    logic        rsvd_err;
    logic [63:0] acc_upper_q;
    logic [63:0] acc_bottom_q;
    logic [63:0] hl;
    int          err_count;
    int          check_count;
    int          n_short;
    int          n_long;

    iexdp_top dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
        .req(req), .mem_word(mem_word), .cop_val(cop_val), .busy(busy),
        .wb(wb), .mem_addr(mem_addr), .addr_err(addr_err),
        .rsvd_err(rsvd_err), .acc_upper_q(acc_upper_q),
        .acc_bottom_q(acc_bottom_q));
    iexdp_mem_model part (.req(req), .mem_word(mem_word), .cop_val(cop_val));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic iexdp_req_t mk(iexdp_op_t op, logic [4:0] t,
        logic [15:0] o, logic [63:0] b, logic [63:0] s, logic [63:0] tv);
        mk = '{op: op, src_sel: 5'h01, tgt_sel: t, dst_sel: 5'h1d,
            offset: o, cop_sel: 2'h1, src_val: s, tgt_val: tv, base_val: b};
    endfunction
    function automatic logic [31:0] memw(logic [63:0] a);
        memw = {a[31:2], 2'b00} ^ 32'h9c3a_5e71;
    endfunction
    function automatic logic [63:0] merge(logic [63:0] old,
        logic [63:0] ea);
        logic [31:0] w;
        logic [31:0] m;
        w = memw(ea);
        m = 32'hffff_ffff >> (8 * ea[1:0]);
        if (ea[1:0] == 2'h0) merge = {{32{w[31]}}, w};
        else merge = {old[63:32], (w >> (8 * ea[1:0])) | (old[31:0] & ~m)};
    endfunction
    // request held up to the taking edge, answer read just after it
    task automatic issue(input iexdp_req_t r);
        req_valid = 1'b1;
        req = r;
        @(posedge mclk);
        #1;
    endtask
    task automatic idle();
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_lwr();
        logic [63:0] e;
        logic [63:0] old;
        old = 64'h1122_3344_5566_7788;
        for (int i = 0; i < 4; i++) begin
            issue(mk(IEXDP_OP_LWR, 5'(i) + 5'h04, 16'hfff0,
                64'h2010 + i, 0, old));
            e = merge(old, 64'h2000 + i);
            chk(wb.wr_val, e);
            chk(mem_addr, 64'h2000 + i);
            chk(64'(wb.wr_sel), 64'h04 + i);
            idle();
        end
        issue(mk(IEXDP_OP_LWR, 5'h09, 16'h0000, 64'h3000, 0, 0));
        e = merge(0, 64'h3000);
        chk(wb.wr_val, e);
        issue(mk(IEXDP_OP_LWR, 5'h09, 16'h0002, 64'h3000, 0, 0));
        chk(wb.wr_val, merge(e, 64'h3002));
        idle();
        $display("test lwr done");
    endtask
    task automatic t_lwu();
        issue(mk(IEXDP_OP_LWU, 5'h0b, 16'h0008, 64'h4000, 0, '1));
        chk(wb.wr_val, {32'h0, memw(64'h4008)});
        chk(64'(wb.wr_sel), 64'h0b);
        issue(mk(IEXDP_OP_LWU, 5'h0b, 16'h0000, 64'h4002, 0, 0));
        chk(64'(addr_err), 64'h1);
        chk(64'(wb.wr_en), 64'h0);
        idle();
        $display("test lwu done");
    endtask
    task automatic t_mac(input iexdp_op_t op, input logic [63:0] s,
        input logic [63:0] t, output int n);
        logic [63:0] p;
        if (op == IEXDP_OP_MACS) p = $signed(s[31:0]) * $signed(t[31:0]);
        else p = {32'h0, s[31:0]} * {32'h0, t[31:0]};
        hl = {hl[63:32], hl[31:0]} + p;
        issue(mk(op, 5'h02, 16'h0000, 0, s, t));
        req_valid = 1'b0;
        chk(64'(busy), 64'h1);
        n = 0;
        while (acc_bottom_q !== {{32{hl[31]}}, hl[31:0]} && n < 6) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 6) begin
            err_count++;
            give_verdict();
        end
        chk(acc_upper_q, {{32{hl[63]}}, hl[63:32]});
        chk(acc_bottom_q, {{32{hl[31]}}, hl[31:0]});
        idle();
        idle();
        $display("test mac done");
    endtask
    task automatic t_mf();
        iexdp_req_t r;
        issue(mk(IEXDP_OP_MFU, 5'h03, 0, 0, 0, 0));
        chk(wb.wr_val, {{32{hl[63]}}, hl[63:32]});
        chk(64'(wb.wr_sel), 64'h1d);
        issue(mk(IEXDP_OP_MFB, 5'h03, 0, 0, 0, 0));
        chk(wb.wr_val, {{32{hl[31]}}, hl[31:0]});
        r = mk(IEXDP_OP_MFC, 5'h0e, 0, 0, 0, 0);
        issue(r);
        chk(wb.wr_val, 64'h8765_4320_0fed_cbb4);
        chk(64'(wb.wr_sel), 64'h0e);
        r.cop_sel = IEXDP_COP_RSVD;
        issue(r);
        chk(64'(rsvd_err), 64'h1);
        chk(64'(wb.wr_en), 64'h0);
        idle();
        $display("test moves done");
    endtask
    task automatic t_mov();
        logic go;
        for (int i = 0; i < 4; i++) begin
            go = (i[1] == 1'b0) == i[0];
            issue(mk(i[1] ? IEXDP_OP_MOVE_IF_ZERO : IEXDP_OP_MOVNZ, 5'h05, 0, 0,
                64'hdead_beef_0123_4567, i[0] ? 64'h1_0000_0000 : 0));
            chk(64'(wb.wr_en), 64'(go));
            if (go) chk(wb.wr_val, 64'hdead_beef_0123_4567);
            idle();
        end
        $display("test cond moves done");
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        hl = IEXDP_ACC_RST;
        err_count = 0;
        check_count = 0;
        repeat (20) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        chk(acc_upper_q, IEXDP_ZERO);
        chk(mem_addr, IEXDP_ZERO);
        t_lwr();
        t_lwu();
        t_mac(IEXDP_OP_MACS, 64'hffff_ffff_ffff_fffd, 64'h1234, n_short);
        t_mac(IEXDP_OP_MACU, 64'hffff_ffff_ffff_0001, 64'h8000_0003, n_long);
        chk(64'(n_short < n_long), 64'h1);
        chk(64'(n_short), 64'(IEXDP_MAC_SHORT) + 64'h1);
        chk(64'(n_long), 64'(IEXDP_MAC_LONG) + 64'h1);
        t_mf();
        t_mov();
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: dv/iexdp_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// memory and coprocessor stand-in
// ------------------------------------------------------------
module iexdp_mem_model
    import iexdp_pkg::*;
(
    input  wire iexdp_req_t  req,
    output logic [31:0]      mem_word,
    output logic [63:0]      cop_val
);
    logic [63:0] ea;
    // word pattern follows the aligned address, cop value the select
    always_comb begin
        ea       = req.base_val + {{48{req.offset[15]}}, req.offset};
        mem_word = {ea[31:2], 2'b00} ^ 32'h9c3a_5e71;
        cop_val  = {30'h0, req.cop_sel, 27'h0, req.dst_sel}
                   ^ 64'h8765_4321_0fed_cba9;
    end
endmodule
`default_nettype wire

/* File: src/iexdp_lwr_merge.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// right-part word merge
// ------------------------------------------------------------
module iexdp_lwr_merge
    import iexdp_pkg::*;
(
    input  wire logic [63:0] old_val,
    input  wire logic [31:0] mem_word,
    input  wire logic [1:0]  byte_ofs,
    output logic      [63:0] merged
);
    logic [31:0] low_word;

    // keep upper bytes, insert fetched low bytes
    always_comb begin
        low_word = old_val[31:0];
        unique case (byte_ofs)
            2'h0: low_word = mem_word;
            2'h1: low_word = {old_val[31:24], mem_word[31:8]};
            2'h2: low_word = {old_val[31:16], mem_word[31:16]};
            2'h3: low_word = {old_val[31:8], mem_word[31:24]};
        endcase
        // full word fetched: sign extend, else leave upper alone
        if (byte_ofs == 2'h0) begin
            merged = {{32{low_word[31]}}, low_word};
        end else begin
            merged = {old_val[63:32], low_word};
        end
    end
endmodule
`default_nettype wire

/* File: src/iexdp_pkg.sv */
package iexdp_pkg;
    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IEXDP_OP_NONE  = 4'h0,
        IEXDP_OP_LWR   = 4'h1,
        IEXDP_OP_LWU   = 4'h2,
        IEXDP_OP_MACS  = 4'h3,
        IEXDP_OP_MACU  = 4'h4,
        IEXDP_OP_MFC   = 4'h5,
        IEXDP_OP_MFU   = 4'h6,
        IEXDP_OP_MFB   = 4'h7,
        IEXDP_OP_MOVNZ = 4'h8,
        IEXDP_OP_MOVE_IF_ZERO  = 4'h9
    } iexdp_op_t;

    typedef struct packed {
        iexdp_op_t   op;
        logic [4:0]  src_sel;
        logic [4:0]  tgt_sel;
        logic [4:0]  dst_sel;
        logic [15:0] offset;
        logic [1:0]  cop_sel;
        logic [63:0] src_val;
        logic [63:0] tgt_val;
        logic [63:0] base_val;
    } iexdp_req_t;

    typedef struct packed {
        logic        wr_en;
        logic [4:0]  wr_sel;
        logic [63:0] wr_val;
    } iexdp_wb_t;

    typedef enum logic [2:0] {
        IEXDP_ST_IDLE = 3'b001,
        IEXDP_ST_MAC  = 3'b010,
        IEXDP_ST_DONE = 3'b100
    } iexdp_state_t;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [1:0]  IEXDP_COP_RSVD   = 2'h3;
    localparam logic [63:0] IEXDP_ACC_RST    = 64'h0000_0000_0000_0000;
    localparam logic [63:0] IEXDP_ZERO       = 64'h0000_0000_0000_0000;
    localparam logic [1:0]  IEXDP_MAC_SHORT  = 2'h1;
    localparam logic [1:0]  IEXDP_MAC_LONG   = 2'h2;
endpackage

/* File: src/iexdp_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - back-to-back right load to same register forwards
// - full right load copies bit 31 upward
// - unsigned load zero-extends aligned word
// - address is base plus sign-extended offset
// - misaligned unsigned load raises address error
// - signed multiply added to accumulator pair
// - sum halves go to upper and bottom
// - small operands finish multiply faster
// - coprocessor register copied to target register
// - coprocessor 3 gives reserved instruction error
// - upper accumulator copied to destination
// - bottom accumulator copied to destination
// - move when target register nonzero
// - move when target register zero
module iexdp_top
    import iexdp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        req_valid,
    input  wire iexdp_req_t  req,
    input  wire logic [31:0] mem_word,
    input  wire logic [63:0] cop_val,
    output logic             busy,
    output var iexdp_wb_t    wb,
    output logic [63:0]      mem_addr,
    output logic             addr_err,
    output logic             rsvd_err,
    output logic [63:0]      acc_upper_q,
    output logic [63:0]      acc_bottom_q
);
    // ------------------------------------------------------------
    // address and load merge
    // ------------------------------------------------------------
    logic [63:0]  eff_addr;
    logic [63:0]  merge_base;
    logic [63:0]  merged;
    iexdp_wb_t    last_load_q;
    logic         fwd_hit;
    iexdp_state_t state_q;
    logic [1:0]   mac_cnt_q;
    logic [63:0]  prod_q;
    logic [63:0]  acc_sum;
    logic         small_ops;
    logic         take;

    assign take = req_valid && (state_q == IEXDP_ST_IDLE);
    // effective address
    assign eff_addr = req.base_val
                    + {{48{req.offset[15]}}, req.offset};
    // forward previous load to same register
    assign fwd_hit = last_load_q.wr_en
                   && (last_load_q.wr_sel == req.tgt_sel);
    assign merge_base = fwd_hit ? last_load_q.wr_val : req.tgt_val;

    iexdp_lwr_merge u_merge (
        .old_val  (merge_base),
        .mem_word (mem_word),
        .byte_ofs (eff_addr[1:0]),
        .merged   (merged)
    );

    // ------------------------------------------------------------
    // multiply accumulate
    // ------------------------------------------------------------
    assign acc_sum = {acc_upper_q[31:0], acc_bottom_q[31:0]} + prod_q;
    // short path when both operands' low words sign-extend from bit 15, for signed and unsigned multiply
    assign small_ops = (req.src_val[31:16] == {16{req.src_val[15]}})
                     && (req.tgt_val[31:16] == {16{req.tgt_val[15]}});

    // sequencer for multiply latency
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q   <= IEXDP_ST_IDLE;
            mac_cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                IEXDP_ST_IDLE: begin
                    if (take && (req.op == IEXDP_OP_MACS
                                 || req.op == IEXDP_OP_MACU)) begin
                        state_q   <= IEXDP_ST_MAC;
                        mac_cnt_q <= small_ops ? IEXDP_MAC_SHORT
                                               : IEXDP_MAC_LONG;
                    end
                end
                IEXDP_ST_MAC: begin
                    if (mac_cnt_q == 2'h1) begin
                        state_q <= IEXDP_ST_DONE;
                    end
                    mac_cnt_q <= mac_cnt_q - 2'h1;
                end
                IEXDP_ST_DONE: begin
                    state_q <= IEXDP_ST_IDLE;
                end
            endcase
        end
    end

    // product capture
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prod_q <= IEXDP_ZERO;
        end else if (take && req.op == IEXDP_OP_MACS) begin
            prod_q <= $signed({{32{req.src_val[31]}}, req.src_val[31:0]})
                    * $signed({{32{req.tgt_val[31]}},
                               req.tgt_val[31:0]});
        end else if (take && req.op == IEXDP_OP_MACU) begin
            prod_q <= {32'h0000_0000, req.src_val[31:0]}
                    * {32'h0000_0000, req.tgt_val[31:0]};
        end
    end

    // accumulator pair
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_upper_q  <= IEXDP_ACC_RST;
            acc_bottom_q <= IEXDP_ACC_RST;
        end else if (state_q == IEXDP_ST_DONE) begin
            acc_bottom_q <= {{32{acc_sum[31]}}, acc_sum[31:0]};
            acc_upper_q  <= {{32{acc_sum[63]}}, acc_sum[63:32]};
        end
    end

    // busy flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_q == IEXDP_ST_MAC && mac_cnt_q != 2'h1)
                 || (take && (req.op == IEXDP_OP_MACS
                              || req.op == IEXDP_OP_MACU));
        end
    end

    // ------------------------------------------------------------
    // write-back and errors
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wb       <= '0;
            mem_addr <= IEXDP_ZERO;
            addr_err <= 1'b0;
            rsvd_err <= 1'b0;
        end else begin
            wb       <= '0;
            addr_err <= 1'b0;
            rsvd_err <= 1'b0;
            if (take) begin
                mem_addr <= eff_addr;
                unique case (req.op)
                    IEXDP_OP_LWR: begin
                        wb <= '{1'b1, req.tgt_sel, merged};
                    end
                    IEXDP_OP_LWU: begin
                        if (eff_addr[1:0] != 2'h0) begin
                            addr_err <= 1'b1;
                        end else begin
                            wb <= '{1'b1, req.tgt_sel,
                                    {32'h0000_0000, mem_word}};
                        end
                    end
                    IEXDP_OP_MFC: begin
                        if (req.cop_sel == IEXDP_COP_RSVD) begin
                            rsvd_err <= 1'b1;
                        end else begin
                            wb <= '{1'b1, req.tgt_sel, cop_val};
                        end
                    end
                    IEXDP_OP_MFU: begin
                        wb <= '{1'b1, req.dst_sel, acc_upper_q};
                    end
                    IEXDP_OP_MFB: begin
                        wb <= '{1'b1, req.dst_sel, acc_bottom_q};
                    end
                    IEXDP_OP_MOVNZ: begin
                        wb <= '{(req.tgt_val != IEXDP_ZERO),
                                req.dst_sel, req.src_val};
                    end
                    IEXDP_OP_MOVE_IF_ZERO: begin
                        wb <= '{(req.tgt_val == IEXDP_ZERO),
                                req.dst_sel, req.src_val};
                    end
                    default: begin
                        wb <= '0;
                    end
                endcase
            end
        end
    end

    // remember last load for forwarding
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            last_load_q <= '0;
        end else if (take) begin
            last_load_q <= '0;
            if (req.op == IEXDP_OP_LWR) begin
                last_load_q <= '{1'b1, req.tgt_sel, merged};
            end else if (req.op == IEXDP_OP_LWU
                         && eff_addr[1:0] == 2'h0) begin
                last_load_q <= '{1'b1, req.tgt_sel,
                                 {32'h0000_0000, mem_word}};
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_mac_take;
        take && (req.op == IEXDP_OP_MACS || req.op == IEXDP_OP_MACU);
    endsequence

    a_mac_latency: assert property (@(posedge mclk)
        disable iff (!rst_b)
        s_mac_take |-> ##[2:3] (state_q == IEXDP_ST_DONE))
        else $error("multiply did not finish in time");
    a_lwu_align: assert property (@(posedge mclk) disable iff (!rst_b)
        take && req.op == IEXDP_OP_LWU && eff_addr[1:0] != 2'h0
        |=> addr_err && !wb.wr_en)
        else $error("misaligned unsigned load not trapped");
    a_lwu_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        take && req.op == IEXDP_OP_LWU && eff_addr[1:0] == 2'h0
        |=> wb.wr_en && wb.wr_val[63:32] == 32'h0000_0000)
        else $error("unsigned load upper not zero");
    a_cop3_rsvd: assert property (@(posedge mclk)
        disable iff (!rst_b)
        take && req.op == IEXDP_OP_MFC && req.cop_sel == IEXDP_COP_RSVD
        |=> rsvd_err && !wb.wr_en)
        else $error("coprocessor 3 move not trapped");
    a_move_if_zero_cond: assert property (@(posedge mclk)
        disable iff (!rst_b)
        take && req.op == IEXDP_OP_MOVE_IF_ZERO
        |=> wb.wr_en == ($past(req.tgt_val) == IEXDP_ZERO))
        else $error("zero move condition wrong");
    a_move_if_nonzero_cond: assert property (@(posedge mclk)
        disable iff (!rst_b)
        take && req.op == IEXDP_OP_MOVNZ
        |=> wb.wr_en == ($past(req.tgt_val) != IEXDP_ZERO))
        else $error("nonzero move condition wrong");
    a_acc_sext: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(state_q) == IEXDP_ST_DONE
        |-> acc_bottom_q[63:32] == {32{acc_bottom_q[31]}}
         && acc_upper_q[63:32] == {32{acc_upper_q[31]}})
        else $error("accumulator not sign extended");
    a_mfu_copy: assert property (@(posedge mclk) disable iff (!rst_b)
        take && req.op == IEXDP_OP_MFU
        |=> wb.wr_en && wb.wr_val == $past(acc_upper_q))
        else $error("upper move wrong value");
    a_addr_form: assert property (@(posedge mclk) disable iff (!rst_b)
        take |=> mem_addr == $past(req.base_val)
                 + {{48{$past(req.offset[15])}}, $past(req.offset)})
        else $error("effective address wrong");
endmodule
`default_nettype wire
